// [pkg/mpf_pkg.sv]
// constants, types and register map of the motor protection fault logic
// Overview of operation
// - fault_out high during regulator lockout, overcurrent, thermal, lock, reverse, hall fault
// - after an overcurrent trip fault_out stays high for the 15 ms hold
// - regulator at or below 3.6 V turns all drives off until 4.0 V
// - bootstrap at or below 10.0 V turns high side off until 10.5 V
// - low-side supply at or below 11.0 V turns all off until 11.5 V
// - sense at 0.50 V for 1.9 us cuts drive until next PWM cycle
// - sense at 0.8 V for 1.3 us cuts drive for hold, fault_out raised
// - above 130 degrees all off with fault, released at 90 degrees
// - no position change for 6 s: all off 35 s with fault, then resume
// - fault_out high while rotation opposes selected direction, low otherwise
// - reverse rotation switches to trapezoidal drive within one 60 degree step
// - direction_select low means reverse; sinusoidal when matching, trapezoidal when opposed
// - position signals all high or all low: all off and fault_out high
// - test mode disables thermal shutdown and forces zero phase advance
package mpf_pkg;
  // clock and timing, each time in its printed unit
  localparam int          CLK_MHZ      = 200;
  localparam longint      CLK_HZ       = longint'(CLK_MHZ) * 1000000;
  localparam int          OCL_BLANK_NS = 1900;
  localparam int          OCP_BLANK_NS = 1300;
  localparam int          OCP_HOLD_MS  = 15;
  localparam int          LOCK_DET_S   = 6;
  localparam int          LOCK_OFF_S   = 35;
  localparam int          BLANK_W      = 12;
  localparam int          LONG_W       = 36;
  // least times round up to whole cycles
  localparam logic [11:0] OCL_BLANK_CYC = 12'((OCL_BLANK_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] OCP_BLANK_CYC = 12'((OCP_BLANK_NS * CLK_MHZ + 999) / 1000);
  localparam logic [35:0] OCP_HOLD_CYC  = 36'((longint'(OCP_HOLD_MS) * CLK_HZ + 999) / 1000);
  localparam logic [35:0] LOCK_DET_CYC  = 36'(longint'(LOCK_DET_S) * CLK_HZ);
  localparam logic [35:0] LOCK_OFF_CYC  = 36'(longint'(LOCK_OFF_S) * CLK_HZ);
  // register map, byte addresses
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
  localparam logic [7:0]  REG_IRQ_EN   = 8'h0C;
  localparam logic [7:0]  REG_IRQ_CLR  = 8'h10;
  localparam int          CTRL_LOCK_EN = 0;
  localparam logic [0:0]  CTRL_RST     = 1'h1;
  // event and status bit positions
  localparam int          EV_REG_UV  = 0;
  localparam int          EV_LS_UV   = 1;
  localparam int          EV_BOOT_UV = 2;
  localparam int          EV_OCL     = 3;
  localparam int          EV_OCP     = 4;
  localparam int          EV_TSD     = 5;
  localparam int          EV_LOCK    = 6;
  localparam int          EV_REV     = 7;
  localparam int          EV_HALL    = 8;
  localparam int          EV_N       = 9;
  localparam logic [8:0]  IRQ_EN_RST = 9'h000;
  // hysteresis latch slots: regulator, low side, three bootstraps, thermal
  localparam int          HY_REG  = 0;
  localparam int          HY_LS   = 1;
  localparam int          HY_BOOT = 2;
  localparam int          HY_TSD  = 5;
  localparam int          HY_N    = 6;
  localparam int          SYNC_W  = 17;
  localparam logic [2:0]  HALL_BAD = 3'h7;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } mpf_gate_s;

  typedef enum {OCP_IDLE, OCP_HOLD} mpf_ocp_e;
  typedef enum {LK_WATCH, LK_OFF}   mpf_lock_e;
endpackage : mpf_pkg

// [rtl/mpf_sync.sv]
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module mpf_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // clock
  input  wire logic         presetn, // async reset, low
  input  wire logic [W-1:0] d,       // raw pin levels
  output logic      [W-1:0] q        // synchronised levels
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : mpf_sync

// [rtl/mpf_persist.sv]
// counts cycles while a condition holds, flags when N reached
`timescale 1ns/100ps
module mpf_persist #(
  parameter int           W = 12,
  parameter logic [W-1:0] N = '1
) (
  input  wire logic pclk,    // clock
  input  wire logic presetn, // async reset, low
  input  wire logic run,     // condition to time
  output logic      done     // condition held N cycles
);
  logic [W-1:0] cnt_q;

  // restarts whenever the condition drops; saturates at N
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (cnt_q != N) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = run && (cnt_q == N);
endmodule : mpf_persist

// [rtl/mpf_fault_logic.sv]
// protection supervisor: lockouts, overcurrent, thermal, lock, direction, apb regs
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module mpf_fault_logic #(
  parameter logic [35:0] OCP_HOLD_CYC = mpf_pkg::OCP_HOLD_CYC,
  parameter logic [35:0] LOCK_DET_CYC = mpf_pkg::LOCK_DET_CYC,
  parameter logic [35:0] LOCK_OFF_CYC = mpf_pkg::LOCK_OFF_CYC
) (
  input  wire logic              pclk,                  // 200 MHz clock
  input  wire logic              presetn,               // async reset, low
  input  wire logic              psel,                  // apb select
  input  wire logic              penable,               // apb enable
  input  wire logic              pwrite,                // apb write
  input  wire logic [7:0]        paddr,                 // apb byte address
  input  wire logic [31:0]       pwdata,                // apb write data
  output logic      [31:0]       prdata,                // apb read data
  output logic                   pready,                // apb ready
  output logic                   pslverr,               // apb error
  input  wire logic              position_u,            // hall u
  input  wire logic              position_v,            // hall v
  input  wire logic              position_w,            // hall w
  input  wire logic              direction_select,      // high forward
  input  wire logic              test_mode,             // test mode strap
  input  wire logic              regulator_output_low,  // at/below 3.6 V
  input  wire logic              regulator_output_ok,   // at/above 4.0 V
  input  wire logic              lowside_supply_low,    // at/below 11.0 V
  input  wire logic              lowside_supply_ok,     // at/above 11.5 V
  input  wire logic [2:0]        bootstrap_supply_low,  // at/below 10.0 V
  input  wire logic [2:0]        bootstrap_supply_ok,   // at/above 10.5 V
  input  wire logic              temp_hot,              // above 130 C
  input  wire logic              temp_cool,             // at/below 90 C
  input  wire logic              sense_limit,           // sense >= 0.50 V
  input  wire logic              sense_trip,            // sense >= 0.8 V
  input  wire logic              pwm_cycle_start,       // new pwm cycle pulse
  input  wire mpf_pkg::mpf_gate_s drive_cmd,            // waveform drive request
  output mpf_pkg::mpf_gate_s     gate,                  // gated transistor drive
  output logic                   fault_out,             // fault pin
  output logic                   sine_mode,             // 1 sinusoidal, 0 trapezoidal
  output logic                   advance_zero,          // phase advance forced 0
  output logic                   irq                    // level interrupt
);
  logic [mpf_pkg::SYNC_W-1:0] raw;
  logic [mpf_pkg::SYNC_W-1:0] syn;
  logic [2:0]                 hall;
  logic                       dir_fwd;
  logic                       test_s;
  logic [mpf_pkg::HY_N-1:0]   hy_set;
  logic [mpf_pkg::HY_N-1:0]   hy_clr;
  logic [mpf_pkg::HY_N-1:0]   hy_q;
  logic                       lim_s;
  logic                       trip_s;

  // every comparator flag is a pin level, so all pass two flops
  assign raw = {position_u, position_v, position_w, direction_select, test_mode,
                regulator_output_low, regulator_output_ok, lowside_supply_low,
                lowside_supply_ok, bootstrap_supply_low, bootstrap_supply_ok,
                temp_hot, temp_cool};

  mpf_sync #(.W(mpf_pkg::SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw),
    .q       (syn)
  );

  mpf_sync #(.W(2)) u_sync_sense (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sense_limit, sense_trip}),
    .q       ({lim_s, trip_s})
  );

  assign hall    = syn[16:14];
  assign dir_fwd = syn[13];
  assign test_s  = syn[12];
  // low flag sets the latch, ok flag releases it
  assign hy_set  = {syn[1], syn[7:5], syn[9], syn[11]};
  assign hy_clr  = {syn[0], syn[4:2], syn[8], syn[10]};

  // hysteresis latches; trip wins if both flags ever overlap
  for (genvar i = 0; i < mpf_pkg::HY_N; i++) begin : g_hy
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hy_q[i] <= 1'b0;
      end else if (hy_set[i]) begin
        hy_q[i] <= 1'b1;
      end else if (hy_clr[i]) begin
        hy_q[i] <= 1'b0;
      end
    end
  end

  logic       reg_uv;
  logic       ls_uv;
  logic [2:0] boot_uv;
  logic       tsd_act;
  assign reg_uv  = hy_q[mpf_pkg::HY_REG];
  assign ls_uv   = hy_q[mpf_pkg::HY_LS];
  assign boot_uv = hy_q[mpf_pkg::HY_BOOT +: 3];
  // test mode masks thermal shutdown
  assign tsd_act = hy_q[mpf_pkg::HY_TSD] && !test_s;

  // overcurrent blanking filters
  logic ocl_hit;
  logic ocp_hit;
  mpf_persist #(.W(mpf_pkg::BLANK_W), .N(mpf_pkg::OCL_BLANK_CYC)) u_ocl_blank (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (lim_s),
    .done    (ocl_hit)
  );
  mpf_persist #(.W(mpf_pkg::BLANK_W), .N(mpf_pkg::OCP_BLANK_CYC)) u_ocp_blank (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (trip_s),
    .done    (ocp_hit)
  );

  // limit latch; a fresh hit beats the cycle release so no trip is lost
  logic ocl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocl_q <= 1'b0;
    end else if (ocl_hit) begin
      ocl_q <= 1'b1;
    end else if (pwm_cycle_start) begin
      ocl_q <= 1'b0;
    end
  end

  // overcurrent hold state machine
  mpf_pkg::mpf_ocp_e ocp_st_q;
  logic              ocp_hold;
  logic              ocp_done;
  assign ocp_hold = (ocp_st_q == mpf_pkg::OCP_HOLD);
  mpf_persist #(.W(mpf_pkg::LONG_W), .N(OCP_HOLD_CYC)) u_ocp_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ocp_hold),
    .done    (ocp_done)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocp_st_q <= mpf_pkg::OCP_IDLE;
    end else begin
      case (ocp_st_q)
        mpf_pkg::OCP_IDLE: if (ocp_hit) ocp_st_q <= mpf_pkg::OCP_HOLD;
        mpf_pkg::OCP_HOLD: if (ocp_done) ocp_st_q <= mpf_pkg::OCP_IDLE;
        default:           ocp_st_q <= mpf_pkg::OCP_IDLE;
      endcase
    end
  end

  // position tracking on the forward sequence 101,100,110,010,011,001
  function automatic logic [2:0] hidx(input logic [2:0] h);
    case (h)
      3'h5:    hidx = 3'h0;
      3'h4:    hidx = 3'h1;
      3'h6:    hidx = 3'h2;
      3'h2:    hidx = 3'h3;
      3'h3:    hidx = 3'h4;
      3'h1:    hidx = 3'h5;
      default: hidx = mpf_pkg::HALL_BAD;
    endcase
  endfunction : hidx

  logic [2:0] hall_prev_q;
  logic [2:0] cur;
  logic [2:0] prv;
  logic       hall_step;
  logic       step_fwd;
  logic       step_rev;
  logic       hall_abn;
  assign cur       = hidx(hall);
  assign prv       = hidx(hall_prev_q);
  assign hall_step = (hall != hall_prev_q);
  // sync stages read zero straight after reset; hold off the hall check until both
  // have filled, else every reset would flash a false fault and a sticky event
  logic [1:0] fill_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 2'h0;
    end else begin
      fill_q <= {fill_q[0], 1'h1};
    end
  end
  // all-high or all-low is no valid position
  assign hall_abn  = fill_q[1] && ((hall == 3'h0) || (hall == 3'h7));
  assign step_fwd  = hall_step && cur != mpf_pkg::HALL_BAD && prv != mpf_pkg::HALL_BAD
                     && cur == ((prv == 3'h5) ? 3'h0 : prv + 3'h1);
  assign step_rev  = hall_step && cur != mpf_pkg::HALL_BAD && prv != mpf_pkg::HALL_BAD
                     && cur == ((prv == 3'h0) ? 3'h5 : prv - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_prev_q <= 3'h0;
    end else begin
      hall_prev_q <= hall;
    end
  end

  // motor lock state machine
  mpf_pkg::mpf_lock_e lk_st_q;
  logic               lock_en_q;
  logic               lk_off;
  logic               lk_det;
  logic               lk_rel;
  assign lk_off = (lk_st_q == mpf_pkg::LK_OFF);
  // any position change restarts the detect interval
  mpf_persist #(.W(mpf_pkg::LONG_W), .N(LOCK_DET_CYC)) u_lock_det (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (lock_en_q && !lk_off && !hall_step),
    .done    (lk_det)
  );
  mpf_persist #(.W(mpf_pkg::LONG_W), .N(LOCK_OFF_CYC)) u_lock_off (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (lk_off),
    .done    (lk_rel)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_st_q <= mpf_pkg::LK_WATCH;
    end else begin
      case (lk_st_q)
        mpf_pkg::LK_WATCH: if (lk_det) lk_st_q <= mpf_pkg::LK_OFF;
        mpf_pkg::LK_OFF:   if (lk_rel) lk_st_q <= mpf_pkg::LK_WATCH;
        default:           lk_st_q <= mpf_pkg::LK_WATCH;
      endcase
    end
  end

  // rotation sense; a stalled motor forgets its direction
  logic fwd_q;
  logic rot_q;
  logic rev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q <= 1'b1;
      rot_q <= 1'b0;
    end else begin
      if (step_fwd) fwd_q <= 1'b1;
      else if (step_rev) fwd_q <= 1'b0;
      if (step_fwd || step_rev) rot_q <= 1'b1;
      else if (lk_det) rot_q <= 1'b0;
    end
  end
  // first opposing step flips the drive, well inside 60 degrees
  assign rev = rot_q && (fwd_q != dir_fwd);

  // drive gating and fault pin, registered
  logic all_off;
  logic fault_d;
  assign all_off = reg_uv || ls_uv || ocl_q || ocp_hold || tsd_act || lk_off || hall_abn;
  assign fault_d = reg_uv || ocp_hold || tsd_act || lk_off || rev || hall_abn;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate         <= '0;
      fault_out    <= 1'b0;
      sine_mode    <= 1'b1;
      advance_zero <= 1'b0;
    end else begin
      gate.ls      <= all_off ? 3'h0 : drive_cmd.ls;
      gate.hs      <= all_off ? 3'h0 : (drive_cmd.hs & ~boot_uv);
      fault_out    <= fault_d;
      sine_mode    <= !rev;
      advance_zero <= test_s;
    end
  end

  // events are rising edges of each protection level
  logic [mpf_pkg::EV_N-1:0] lvl;
  logic [mpf_pkg::EV_N-1:0] lvl_q;
  logic [mpf_pkg::EV_N-1:0] irq_stat_q;
  logic [mpf_pkg::EV_N-1:0] irq_en_q;
  assign lvl = {hall_abn, rev, lk_off, tsd_act, ocp_hold, ocl_q, |boot_uv, ls_uv, reg_uv};
  logic [mpf_pkg::EV_N-1:0] rise;
  assign rise = lvl & ~lvl_q;

  // apb slave, zero wait states
  logic wr;
  logic [mpf_pkg::EV_N-1:0] clr;
  logic mapped;
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign mapped = paddr inside {mpf_pkg::REG_CTRL, mpf_pkg::REG_STATUS,
                                mpf_pkg::REG_IRQ_STAT, mpf_pkg::REG_IRQ_EN,
                                mpf_pkg::REG_IRQ_CLR};
  assign pslverr = psel && penable && !mapped;
  assign clr     = (wr && paddr == mpf_pkg::REG_IRQ_CLR) ? pwdata[mpf_pkg::EV_N-1:0] : '0;

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q      <= '0;
      irq_stat_q <= '0;
    end else begin
      lvl_q      <= lvl;
      irq_stat_q <= (irq_stat_q & ~clr) | rise;
    end
  end

  // control writes; lock detection can be switched off by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_en_q <= mpf_pkg::CTRL_RST[0];
      irq_en_q  <= mpf_pkg::IRQ_EN_RST;
    end else if (wr) begin
      if (paddr == mpf_pkg::REG_CTRL) lock_en_q <= pwdata[mpf_pkg::CTRL_LOCK_EN];
      if (paddr == mpf_pkg::REG_IRQ_EN) irq_en_q <= pwdata[mpf_pkg::EV_N-1:0];
    end
  end

  // read data captured in the setup cycle, valid through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        mpf_pkg::REG_CTRL:     prdata <= {31'h0, lock_en_q};
        mpf_pkg::REG_STATUS:   prdata <= {23'h0, lvl};
        mpf_pkg::REG_IRQ_STAT: prdata <= {23'h0, irq_stat_q};
        mpf_pkg::REG_IRQ_EN:   prdata <= {23'h0, irq_en_q};
        default:               prdata <= 32'h0;
      endcase
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ocp_enter;
    !ocp_hold && ocp_hit;
  endsequence
  sequence s_ocp_held;
    ocp_hold [*8];
  endsequence

  property p_ocp_trip;
    s_ocp_enter |=> s_ocp_held;
  endproperty
  a_ocp_trip: assert property (p_ocp_trip) else $error("ocp hold not entered");

  property p_ocp_fault;
    s_ocp_enter ##1 ocp_hold |=> fault_out && gate == '0;
  endproperty
  a_ocp_fault: assert property (p_ocp_fault) else $error("fault low in ocp hold");

  property p_reg_off;
    reg_uv |=> gate == '0 && fault_out;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("drive on in regulator lockout");

  property p_boot_off;
    boot_uv[0] |=> !gate.hs[0];
  endproperty
  a_boot_off: assert property (p_boot_off) else $error("high side on in boot lockout");

  property p_ls_off;
    ls_uv |=> gate == '0;
  endproperty
  a_ls_off: assert property (p_ls_off) else $error("drive on in supply lockout");

  property p_ocl;
    ocl_hit |=> ocl_q ##1 gate == '0;
  endproperty
  a_ocl: assert property (p_ocl) else $error("limit did not cut drive");

  property p_tsd;
    hy_q[mpf_pkg::HY_TSD] && !test_s |=> fault_out && gate == '0;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown missed");

  property p_lock;
    lk_det && !lk_off |=> lk_off ##1 fault_out;
  endproperty
  a_lock: assert property (p_lock) else $error("lock protection missed");

  property p_rev;
    rev |=> !sine_mode && fault_out;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse not flagged");

  property p_hall;
    hall_abn |=> fault_out && gate == '0;
  endproperty
  a_hall: assert property (p_hall) else $error("hall fault not handled");

  property p_quiet;
    !fault_d |=> !fault_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("fault high with no cause");

  property p_set_wins;
    rise != '0 |=> (irq_stat_q & $past(rise)) == $past(rise);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost at clear");
endmodule : mpf_fault_logic

// [verif/mpf_mcu_model.sv]
// controller model: takes fault_out as interrupt, drops drive, waits before restart
`timescale 1ns/100ps
module mpf_mcu_model #(
  parameter int RESTART_CYC = 50
) (
  input  wire logic pclk,      // clock
  input  wire logic presetn,   // async reset, low
  input  wire logic fault_out, // fault pin seen as interrupt
  output logic      drive_en   // high while drive requests may be sent
);
  int cnt_q;
  // drive off at once on fault; restart only after a quiet wait, so repeated
  // shorts cannot hammer the output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 0;
      drive_en <= 1'b1;
    end else if (fault_out) begin
      drive_en <= 1'b0;
      cnt_q    <= RESTART_CYC;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end else begin
      drive_en <= 1'b1;
    end
  end
endmodule : mpf_mcu_model

// [verif/mpf_fault_logic_bench.sv]
// self-checking bench of the protection supervisor
`timescale 1ns/100ps
module mpf_fault_logic_bench;
  logic pclk, presetn, psel, penable, pwrite, pwm, dir, tmode, slim, strip, den;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ard;
  logic pready, pslverr, aerr, fault_out, sine_mode, advance_zero, irq;
  logic [2:0] hall_v;
  logic [3:0] lo_v, ok_v;
  mpf_pkg::mpf_gate_s drive_cmd, gate;
  int fail_count, cmp_count;
  mpf_fault_logic #(.OCP_HOLD_CYC(36'h14), .LOCK_DET_CYC(36'h28), .LOCK_OFF_CYC(36'h1E))
  u_mpf_fault_logic (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .position_u(hall_v[2]), .position_v(hall_v[1]),
    .position_w(hall_v[0]), .direction_select(dir), .test_mode(tmode),
    .regulator_output_low(lo_v[0]), .regulator_output_ok(ok_v[0]),
    .lowside_supply_low(lo_v[1]), .lowside_supply_ok(ok_v[1]),
    .bootstrap_supply_low({2'b00, lo_v[3]}), .bootstrap_supply_ok({2'b11, ok_v[3]}),
    .temp_hot(lo_v[2]), .temp_cool(ok_v[2]), .sense_limit(slim), .sense_trip(strip),
    .pwm_cycle_start(pwm), .drive_cmd(drive_cmd), .gate(gate), .fault_out(fault_out),
    .sine_mode(sine_mode), .advance_zero(advance_zero), .irq(irq));
  mpf_mcu_model u_mpf_mcu_model (.pclk(pclk), .presetn(presetn), .fault_out(fault_out),
    .drive_en(den));
  // waveform side: full drive request whenever the controller allows it
  always @(posedge pclk) drive_cmd <= den ? mpf_pkg::mpf_gate_s'(6'h3F) : '0;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  // apb master: setup, then access until pready, data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    ard = prdata; aerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic hall(input logic [2:0] h);
    hall_v <= h;
    cyc(6);
  endtask : hall
  task automatic t_regs();
    apb(0, mpf_pkg::REG_CTRL, 0); chk("ctrl rst", 32'h1, ard);
    apb(1, mpf_pkg::REG_CTRL, 0); // lock watch off for the other scenarios
    apb(0, mpf_pkg::REG_IRQ_EN, 0); chk("irq_en rst", 32'h0, ard);
    apb(1, mpf_pkg::REG_IRQ_EN, 32'h1FF); apb(0, mpf_pkg::REG_IRQ_EN, 0);
    chk("irq_en", 32'h1FF, ard);
    apb(0, 8'h14, 0); chk("unmapped err", 32'h1, 32'(aerr)); chk("unmapped rd", 0, ard);
    apb(1, mpf_pkg::REG_STATUS, 32'hFFFFFFFF); apb(0, mpf_pkg::REG_STATUS, 0);
    chk("status", 32'h0, ard);
    apb(0, mpf_pkg::REG_IRQ_CLR, 0); chk("irq_clr rd", 32'h0, ard);
  endtask : t_regs
  // regulator, low side, thermal, bootstrap u: trip, hysteresis, release
  task automatic t_lockouts();
    logic [5:0] eg[4] = '{6'h00, 6'h00, 6'h00, 6'h37};
    logic [0:0] ef[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int eb[4] = '{0, 1, 5, 2};
    for (int i = 0; i < 4; i++) begin
      apb(1, mpf_pkg::REG_IRQ_CLR, 32'h1FF);
      lo_v[i] <= 1'b1; ok_v[i] <= 1'b0;
      cyc(6);
      chk("gate off", 32'(eg[i]), 32'(gate));
      chk("fault", 32'(ef[i]), 32'(fault_out));
      chk("irq", 32'h1, 32'(irq));
      lo_v[i] <= 1'b0;
      cyc(6);
      chk("gate held", 32'(eg[i]), 32'(gate));
      ok_v[i] <= 1'b1;
      cyc(70);
      chk("gate back", 32'h3F, 32'(gate));
      chk("fault clr", 32'h0, 32'(fault_out));
      apb(0, mpf_pkg::REG_IRQ_STAT, 0); chk("sticky", 32'h1, 32'(ard[eb[i]]));
    end
  endtask : t_lockouts
  task automatic t_test_mode();
    tmode <= 1'b1; lo_v[2] <= 1'b1; ok_v[2] <= 1'b0;
    cyc(6);
    chk("advance zero", 32'h1, 32'(advance_zero));
    chk("no thermal", 32'h0, 32'(fault_out)); chk("gate", 32'h3F, 32'(gate));
    lo_v[2] <= 1'b0; ok_v[2] <= 1'b1;
    cyc(4);
    tmode <= 1'b0;
    cyc(6);
  endtask : t_test_mode
  task automatic t_overcurrent();
    slim <= 1'b1; cyc(390);
    chk("limit gate", 0, 32'(gate)); chk("limit fault", 0, 32'(fault_out));
    slim <= 1'b0; cyc(6);
    chk("limit kept", 0, 32'(gate));
    pwm <= 1'b1; @(posedge pclk); pwm <= 1'b0; cyc(4);
    chk("limit freed", 32'h3F, 32'(gate));
    strip <= 1'b1; cyc(258);
    chk("trip early", 0, 32'(fault_out));
    cyc(8);
    chk("trip fault", 32'h1, 32'(fault_out)); chk("trip gate", 0, 32'(gate));
    strip <= 1'b0; cyc(10);
    chk("hold", 32'h1, 32'(fault_out));
    cyc(20);
    chk("hold end", 0, 32'(fault_out));
    cyc(60);
    chk("resume", 32'h3F, 32'(gate));
  endtask : t_overcurrent
  task automatic t_hall_dir();
    hall(3'b111);
    chk("hall bad", 32'h1, 32'(fault_out)); chk("hall gate", 0, 32'(gate));
    hall(3'b101); cyc(64);
    chk("hall ok", 0, 32'(fault_out)); chk("hall gate", 32'h3F, 32'(gate));
    hall(3'b100);
    chk("fwd", 0, 32'(fault_out)); chk("sine", 32'h1, 32'(sine_mode));
    hall(3'b101);
    chk("rev", 32'h1, 32'(fault_out)); chk("trap", 0, 32'(sine_mode));
    hall(3'b100);
    chk("fwd again", 0, 32'(fault_out));
    dir <= 1'b0; hall(3'b101);
    chk("rev sel", 0, 32'(fault_out)); chk("sine", 32'h1, 32'(sine_mode));
    hall(3'b100);
    chk("opposed", 32'h1, 32'(fault_out)); chk("trap", 0, 32'(sine_mode));
    dir <= 1'b1; cyc(6);
    chk("match", 0, 32'(fault_out));
  endtask : t_hall_dir
  // lock with the interrupt masked, then unmasked, then cleared
  task automatic t_lock();
    apb(1, mpf_pkg::REG_IRQ_EN, 0); apb(1, mpf_pkg::REG_IRQ_CLR, 32'h1FF);
    apb(1, mpf_pkg::REG_CTRL, 32'h1); cyc(50);
    chk("lock fault", 32'h1, 32'(fault_out)); chk("lock gate", 0, 32'(gate));
    chk("irq masked", 0, 32'(irq));
    apb(0, mpf_pkg::REG_STATUS, 0); chk("status lock", 32'h40, ard);
    apb(1, mpf_pkg::REG_IRQ_EN, 32'h1FF); cyc(1);
    chk("irq on", 32'h1, 32'(irq));
    apb(1, mpf_pkg::REG_CTRL, 0); cyc(40);
    chk("lock over", 0, 32'(fault_out));
    apb(1, mpf_pkg::REG_IRQ_CLR, 32'h1FF); cyc(1);
    chk("irq clr", 0, 32'(irq));
  endtask : t_lock
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // hang guard well beyond the roughly 1400 cycles the scenarios take
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pwm = 1'b0; dir = 1'b1; tmode = 1'b0; slim = 1'b0; strip = 1'b0;
    hall_v = 3'b101; lo_v = 4'h0; ok_v = 4'hF;
    fail_count = 0; cmp_count = 0;
    cyc(2);
    presetn <= 1'b1;
    t_regs();
    t_lockouts();
    t_test_mode();
    t_overcurrent();
    t_hall_dir();
    t_lock();
    print_verdict();
  end
endmodule : mpf_fault_logic_bench
